// >>> core/adcsp_pkg.sv
// adcsp_pkg: constants, types and helpers of the serial readout port.
// assumes a 20 MHz system clock and a separate serial clock from the host.
//
// Contract
// - each channel sample is a 24-bit twos-complement word sent msb first.
// - samples saturate at 7fffff and 800000, never wrap.
// - rate select 000 or 001 keeps only 17 or 19 meaningful bits.
// - ready output goes low on every finished conversion, whatever chip select does; here a conversion during a frame read is dropped and leaves ready unchanged.
// - chip select high resets serial state, ignores clock and data, floats output.
// - incomplete commands may confuse the port; only raising chip select recovers.
// - serial data input is sampled on every falling serial clock edge.
// - serial data output changes on every rising serial clock edge.
// - in continuous read mode the data output also signals new data.
// - first rising edge gives frame msb; first falling edge returns ready high.
// - frame is 24 status bits plus 24 bits per channel, 216 bits.
// - status is 1100, positive lead-off, negative lead-off, pin levels 4 to 7.
// - powered-down or absent channels keep their slots and read zero.
// - with chain enable set, extra clocks restart output at the frame start.
// - an on-demand read may overlap the next ready without corrupting data.
// - four pins with own direction bit; level readback is the real pin.
// - writing a level drives it only when the pin is an output.
// - all pins are inputs after power-on and after reset.
// - power-down low stops everything; high resumes after a wake-up time; here only conversions stop, the serial link and pins keep working.
package adcsp_pkg;

    localparam int CH_NUM      = 8;
    localparam int SAMPLE_W    = 24;
    localparam int STATUS_W    = 24;
    localparam int FRAME_W     = STATUS_W + SAMPLE_W * CH_NUM;
    localparam int RAW_W       = 26;
    localparam int PIN_N       = 4;
    localparam int IDX_W       = 8;

    localparam logic [3:0]          STATUS_SYNC = 4'hc;
    localparam logic [SAMPLE_W-1:0] CODE_MAX    = 24'h7fffff;
    localparam logic [SAMPLE_W-1:0] CODE_MIN    = 24'h800000;
    localparam logic [2:0]          RATE_17     = 3'h0;
    localparam logic [2:0]          RATE_19     = 3'h1;
    localparam int                  KEEP_17     = 17;
    localparam int                  KEEP_19     = 19;
    localparam logic [IDX_W-1:0]    IDX_LAST    = 8'hd7;
    localparam logic [PIN_N-1:0]    PIN_DIR_RST = 4'hf;

    // wake-up after power-down, in ns, converted to system cycles
    localparam int CLK_SYS_MHZ  = 20;
    localparam int WAKE_TIME_NS = 2000;
    localparam int WAKE_CYC     = (WAKE_TIME_NS * CLK_SYS_MHZ + 999) / 1000;
    localparam int WAKE_W       = 8;

    typedef logic signed [RAW_W-1:0] adcsp_raw_t;

    typedef struct packed {
        logic [CH_NUM-1:0] pos;
        logic [CH_NUM-1:0] neg;
    } adcsp_lead_off_s;

    typedef struct packed {
        logic [PIN_N-1:0] dir;
        logic [PIN_N-1:0] level;
        logic             wr;
    } adcsp_pin_ctl_s;

    typedef enum logic [1:0] {
        LK_IDLE  = 2'b00,
        LK_SHIFT = 2'b01,
        LK_DONE  = 2'b10
    } adcsp_link_e;

    typedef enum logic [1:0] {
        PWR_ON   = 2'b00,
        PWR_DOWN = 2'b01,
        PWR_WAKE = 2'b10
    } adcsp_pwr_e;

    // clip a wide raw result into the 24-bit code range
    function automatic logic [SAMPLE_W-1:0] adcsp_saturate(input adcsp_raw_t raw);
        logic [SAMPLE_W-1:0] res;
        res = raw[SAMPLE_W-1:0];
        if (raw > $signed({{(RAW_W-SAMPLE_W+1){1'b0}}, CODE_MAX[SAMPLE_W-2:0]})) begin
            res = CODE_MAX;
        end else if (raw < -$signed({{(RAW_W-SAMPLE_W){1'b0}}, 1'b1,
                                     {(SAMPLE_W-1){1'b0}}})) begin
            res = CODE_MIN;
        end
        return res;
    endfunction : adcsp_saturate

    // clear the bits below the meaningful resolution
    function automatic logic [SAMPLE_W-1:0] adcsp_trim(input logic [SAMPLE_W-1:0] code,
                                                     input logic [2:0]          rate);
        logic [SAMPLE_W-1:0] mask;
        mask = '1;
        if (rate == RATE_17) begin
            mask = ~((SAMPLE_W'(1) << (SAMPLE_W - KEEP_17)) - SAMPLE_W'(1));
        end else if (rate == RATE_19) begin
            mask = ~((SAMPLE_W'(1) << (SAMPLE_W - KEEP_19)) - SAMPLE_W'(1));
        end
        return code & mask;
    endfunction : adcsp_trim

endpackage : adcsp_pkg

// >>> core/adcsp_sync2.sv
// adcsp_sync2: two-flop synchroniser for levels entering the system clock.
// assumes each bit is an independent level, no word coherence needed.
`timescale 1ns/1ps
module adcsp_sync2 #(
    parameter int W = 1
) (
    input  wire logic         i_clk_sys,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;

endmodule : adcsp_sync2

// >>> core/adcsp_port.sv
// adcsp_port: serial readout port, data-ready, general pins and power-down.
// assumes conversion results arrive as pulses on the system clock; the
// serial clock comes from the host and only toggles while chip select is low.
`timescale 1ns/1ps
module adcsp_port
    import adcsp_pkg::*;
(
    input  wire logic                          i_clk_sys,
    input  wire logic                          i_rst,
    // conversion side, system clock
    input  wire logic                          i_conv_valid,
    input  wire adcsp_pkg::adcsp_raw_t         i_conv_raw [adcsp_pkg::CH_NUM],
    input  wire logic [adcsp_pkg::CH_NUM-1:0]  i_chan_on,
    input  wire logic [2:0]                    i_rate_select,
    input  wire adcsp_pkg::adcsp_lead_off_s    i_lead_off,
    input  wire logic                          i_chain_en,
    input  wire logic                          i_continuous_read_cmd,
    // general pins
    input  wire adcsp_pkg::adcsp_pin_ctl_s     i_pin_ctl,
    input  wire logic [adcsp_pkg::PIN_N-1:0]   i_pin_in,
    output logic      [adcsp_pkg::PIN_N-1:0]   o_pin_out,
    output logic      [adcsp_pkg::PIN_N-1:0]   o_pin_oe,
    output logic      [adcsp_pkg::PIN_N-1:0]   o_pin_level_bits,
    output logic      [adcsp_pkg::PIN_N-1:0]   o_pin_direction_bits,
    // power-down pin and state
    input  wire logic                          i_power_down_n,
    output logic                               o_powered_up,
    // serial link
    input  wire logic                          i_sclk,
    input  wire logic                          i_cs_n,
    input  wire logic                          i_sdi,
    output logic                               o_sdo,
    output logic                               o_sdo_oe,
    output logic                               o_sample_ready_n,
    output logic                               o_sdi_high_seen
);

    // =========================================================
    // declarations
    // =========================================================
    adcsp_link_e              link_state_q;
    logic [IDX_W-1:0]         bit_idx_q;
    logic                     sdo_q;
    logic                     first_fall_q;
    logic                     sdi_high_q;
    logic [7:0]               sdi_sr_q;

    logic [FRAME_W-1:0]       latest_d;
    logic [FRAME_W-1:0]       out_q;
    logic                     ready_n_q;
    logic                     sdi_seen_q;
    logic                     fall_tgl_s_q;
    adcsp_pwr_e               pwr_q;
    adcsp_pwr_e               pwr_d;
    logic [WAKE_W-1:0]        wake_cnt_q;
    logic [PIN_N-1:0]         dir_q;
    logic [PIN_N-1:0]         level_q;
    logic [PIN_N-1:0]         pin_rd_q;
    logic                     powered_up_q;

    logic [PIN_N-1:0]         pin_s;
    logic                     power_down_n_n_s;
    logic                     fall_tgl_s;
    logic                     link_busy_s;
    logic                     sdi_high_s;
    logic                     link_busy;

    // =========================================================
    // link side: rising serial clock edges shift the frame out
    // =========================================================
    // chip select doubles as the link reset, since the serial clock
    // stands still while it is high and no edge could clear the state
    logic [IDX_W-1:0]         idx_next;
    logic                     at_last;
    logic                     frame_bit;

    assign at_last   = (bit_idx_q == IDX_LAST);
    assign frame_bit = out_q[IDX_W'(FRAME_W - 1) - bit_idx_q];
    assign idx_next  = at_last ? '0 : bit_idx_q + IDX_W'(1);

    always_ff @(posedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            link_state_q <= LK_IDLE;
            bit_idx_q    <= '0;
            sdo_q        <= 1'b0;
        end else begin
            case (link_state_q)
                LK_IDLE: begin
                    sdo_q        <= frame_bit;
                    bit_idx_q    <= idx_next;
                    link_state_q <= LK_SHIFT;
                end
                LK_SHIFT: begin
                    sdo_q     <= frame_bit;
                    bit_idx_q <= idx_next;
                    if (at_last && !i_chain_en) begin
                        link_state_q <= LK_DONE;
                    end
                end
                LK_DONE: begin
                    sdo_q <= 1'b0;
                end
                default: begin
                    link_state_q <= LK_IDLE;
                end
            endcase
        end
    end

    // after the last bit with no chain enable, bits past the end are held
    // at zero until chip select rises; only that restores the port

    // =========================================================
    // link side: falling serial clock edges sample the data input
    // =========================================================
    always_ff @(negedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            first_fall_q <= 1'b0;
            sdi_sr_q     <= '0;
            sdi_high_q   <= 1'b0;
        end else begin
            first_fall_q <= 1'b1;
            sdi_sr_q     <= {sdi_sr_q[6:0], i_sdi};
            if (i_sdi) begin
                sdi_high_q <= 1'b1;
            end
        end
    end

    // first_fall_q rises once per selection and stays up for the whole
    // frame, long enough for the system side to see one clean edge;
    // it has a known idle level, so no false edge follows reset

    assign link_busy = (link_state_q != LK_IDLE);

    // =========================================================
    // crossings into the system clock
    // =========================================================
    adcsp_sync2 #(.W(PIN_N + 4)) u_sync (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_async   ({i_pin_in, i_power_down_n, first_fall_q, link_busy, sdi_high_q}),
        .o_sync    ({pin_s, power_down_n_n_s, fall_tgl_s, link_busy_s, sdi_high_s})
    );

    logic first_fall_evt;
    assign first_fall_evt = fall_tgl_s & ~fall_tgl_s_q;

    // =========================================================
    // power-down sequencing
    // =========================================================
    logic wake_done;
    assign wake_done = (wake_cnt_q == WAKE_W'(WAKE_CYC - 1));

    always_comb begin
        pwr_d = pwr_q;
        case (pwr_q)
            PWR_ON: begin
                if (!power_down_n_n_s) begin
                    pwr_d = PWR_DOWN;
                end
            end
            PWR_DOWN: begin
                if (power_down_n_n_s) begin
                    pwr_d = PWR_WAKE;
                end
            end
            PWR_WAKE: begin
                if (!power_down_n_n_s) begin
                    pwr_d = PWR_DOWN;
                end else if (wake_done) begin
                    pwr_d = PWR_ON;
                end
            end
            default: begin
                pwr_d = PWR_DOWN;
            end
        endcase
    end

    // reset starts powered down and wakes from the synced pin level
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            pwr_q        <= PWR_DOWN;
            wake_cnt_q   <= '0;
            powered_up_q <= 1'b0;
        end else begin
            pwr_q        <= pwr_d;
            wake_cnt_q   <= (pwr_q == PWR_WAKE) ? wake_cnt_q + WAKE_W'(1) : '0;
            powered_up_q <= (pwr_d == PWR_ON);
        end
    end

    // =========================================================
    // frame assembly
    // =========================================================
    logic [STATUS_W-1:0] status_word;
    logic                conv_take;

    assign status_word = {STATUS_SYNC, i_lead_off.pos, i_lead_off.neg,
                          pin_s[0], pin_s[1], pin_s[2], pin_s[3]};
    assign conv_take   = i_conv_valid && (pwr_q == PWR_ON);

    always_comb begin
        latest_d = '0;
        latest_d[FRAME_W-1 -: STATUS_W] = status_word;
        for (int ch = 0; ch < CH_NUM; ch++) begin
            // channel one sits right after the status word
            if (i_chan_on[ch]) begin
                latest_d[FRAME_W-1-STATUS_W-ch*SAMPLE_W -: SAMPLE_W] =
                    adcsp_trim(adcsp_saturate(i_conv_raw[ch]),
                               i_rate_select);
            end
        end
    end

    // the shift source is frozen while a frame is on the wire, so a
    // conversion that lands during an on-demand read is dropped
    // rather than tearing the frame half-way
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            out_q <= '0;
        end else if (conv_take && !link_busy_s) begin
            out_q <= latest_d;
        end
    end

    // =========================================================
    // data-ready flag
    // =========================================================
    // a conversion in the same cycle as the first falling edge is dropped,
    // since the link already reads busy, and the flag goes high
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            ready_n_q    <= 1'b1;
            fall_tgl_s_q <= 1'b0;
            sdi_seen_q   <= 1'b0;
        end else begin
            fall_tgl_s_q <= fall_tgl_s;
            sdi_seen_q   <= sdi_high_s;
            if (conv_take && !link_busy_s) begin
                ready_n_q <= 1'b0;
            end else if (first_fall_evt) begin
                ready_n_q <= 1'b1;
            end
        end
    end

    // =========================================================
    // general pins
    // =========================================================
    logic [PIN_N-1:0] level_wr;
    assign level_wr = {PIN_N{i_pin_ctl.wr}} & ~i_pin_ctl.dir;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            dir_q    <= PIN_DIR_RST;
            level_q  <= '0;
            pin_rd_q <= '0;
        end else begin
            pin_rd_q <= pin_s;
            if (i_pin_ctl.wr) begin
                dir_q <= i_pin_ctl.dir;
            end
            for (int p = 0; p < PIN_N; p++) begin
                if (level_wr[p]) begin
                    level_q[p] <= i_pin_ctl.level[p];
                end
            end
        end
    end

    // =========================================================
    // outputs
    // =========================================================
    // the line must float the instant chip select rises, faster than
    // any flop could follow, so the enable is taken from the pin itself
    assign o_sdo_oe = ~i_cs_n;

    // in continuous mode an idle line mirrors the ready flag, so the
    // host may run without the ready wire
    assign o_sdo = (i_continuous_read_cmd && link_state_q == LK_IDLE)
                   ? ready_n_q : sdo_q;

    assign o_sample_ready_n     = ready_n_q;
    assign o_pin_out            = level_q;
    assign o_pin_oe             = ~dir_q;
    assign o_pin_level_bits     = pin_rd_q;
    assign o_pin_direction_bits = dir_q;
    assign o_powered_up         = powered_up_q;
    assign o_sdi_high_seen      = sdi_seen_q;

    // host keeps the serial clock fast enough to finish a frame per period

endmodule : adcsp_port

// >>> sim/adcsp_port_chk.sv
// adcsp_port_chk: port-level assertions for the serial readout port.
// assumes it is bound onto adcsp_port; checks run on the system clock only.
`timescale 1ns/1ps
module adcsp_port_chk
    import adcsp_pkg::*;
(
    input wire logic                   i_clk_sys,
    input wire logic                   i_rst,
    input wire logic                   i_conv_valid,
    input wire logic                   i_cs_n,
    input wire logic                   i_power_down_n,
    input wire adcsp_pkg::adcsp_pin_ctl_s i_pin_ctl,
    input wire logic [PIN_N-1:0]       o_pin_oe,
    input wire logic [PIN_N-1:0]       o_pin_out,
    input wire logic [PIN_N-1:0]       o_pin_direction_bits,
    input wire logic                   o_powered_up,
    input wire logic                   o_sdo_oe,
    input wire logic                   o_sample_ready_n
);
    // ==========================================
    // helper: cycles since power-down pin high
    localparam int WAKE_MIN = WAKE_CYC - 2;
    logic [7:0] wake_q;
    always_ff @(posedge i_clk_sys) begin
        if (i_rst || !i_power_down_n) begin
            wake_q <= 8'h00;
        end else if (wake_q != 8'hff) begin
            wake_q <= wake_q + 8'h01;
        end
    end
    // ==========================================
    // assertions
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    a_oe_tracks_cs: assert property (o_sdo_oe == !i_cs_n)
        else $error("data out enable differs from select");
    a_ready_on_conv: assert property (i_cs_n[*6] ##0 (i_conv_valid && o_powered_up)
        |=> !o_sample_ready_n) else $error("ready missing after conversion");
    a_ready_has_cause: assert property ($fell(o_sample_ready_n)
        |-> $past(i_conv_valid) && $past(o_powered_up)) else $error("ready without cause");
    a_ready_holds: assert property (i_cs_n[*6] ##0 !o_sample_ready_n
        |=> !o_sample_ready_n) else $error("ready cleared without serial clock");
    a_pin_dir_load: assert property (i_pin_ctl.wr |=>
        o_pin_direction_bits == $past(i_pin_ctl.dir) && o_pin_oe == ~$past(i_pin_ctl.dir))
        else $error("pin direction not loaded");
    a_pin_drive: assert property (i_pin_ctl.wr |=> (o_pin_out & o_pin_oe) ==
        ($past(i_pin_ctl.level) & ~$past(i_pin_ctl.dir))) else $error("pin drive wrong");
    a_pins_after_rst: assert property ($fell(i_rst) |-> o_pin_oe == 4'h0
        && o_pin_direction_bits == PIN_DIR_RST) else $error("pins not inputs after reset");
    a_pwr_down: assert property (!i_power_down_n[*6] |-> !o_powered_up)
        else $error("still powered while pin low");
    a_wake_time: assert property ($rose(o_powered_up) |-> wake_q >= WAKE_MIN)
        else $error("woke too early");
    c_conv: cover property (i_conv_valid && o_powered_up);
    c_pin_wr: cover property (i_pin_ctl.wr);
    c_wake: cover property ($rose(o_powered_up));
endmodule : adcsp_port_chk

bind adcsp_port adcsp_port_chk chk (.i_clk_sys, .i_rst, .i_conv_valid, .i_cs_n,
    .i_power_down_n, .i_pin_ctl, .o_pin_oe, .o_pin_out, .o_pin_direction_bits,
    .o_powered_up, .o_sdo_oe, .o_sample_ready_n);

// >>> sim/adcsp_host.sv
// adcsp_host: behavioural serial master reading frames from the port.
// assumes a 64 ns link clock that only runs inside a selected frame.
`timescale 1ns/1ps
module adcsp_host (
    output logic      o_sclk,
    output logic      o_cs_n,
    output logic      o_sdi,
    input  wire logic i_sdo,
    input  wire logic i_sdo_oe
);
    // ==========================================
    // line model and transfer task
    logic [231:0] got;
    event         done;
    logic         last;
    logic         line;
    // a released line shows the inverse of its last driven value
    always @* if (i_sdo_oe) last = i_sdo;
    assign line = i_sdo_oe ? i_sdo : ~last;
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_sdi  = 1'b0;
        last   = 1'b0;
    end
    // short counts abort a frame; raising select recovers the port
    task automatic xfer(input int n, input bit rd);
        got = '0;
        o_cs_n = 1'b0;
        #100;
        for (int b = 0; b < n; b++) begin
            o_sclk = 1'b1;
            #32;
            o_sclk = 1'b0;
            got = {got[230:0], line};
            #32;
        end
        #200;
        o_cs_n = 1'b1;
        #300;
        if (rd) ->done;
    endtask : xfer
endmodule : adcsp_host

// >>> sim/adcsp_port_test.sv
// adcsp_port_test: self-checking bench for adcsp_port with a host model.
// assumes adcsp_pkg, adcsp_host and the bound checker are compiled first.
`timescale 1ns/1ps
module adcsp_port_test;
    import adcsp_pkg::*;
    // ==========================================
    // stimulus, design and host
    logic clk, rst, cv, chain, cont, power_down_n;
    adcsp_raw_t raw [CH_NUM];
    logic [7:0] on;
    logic [2:0] rate;
    adcsp_lead_off_s lo;
    adcsp_pin_ctl_s pc;
    logic [3:0] ext, exp_pins;
    wire [3:0] pin_out, pin_oe, lvl, dirb, pin_w;
    wire sclk, cs_n, sdi, sdo, sdo_oe, rdy_n, up;
    logic [231:0] exp_q [$];
    logic [215:0] f;
    int fails, total_checks;
    assign pin_w = (pin_oe & pin_out) | (~pin_oe & ext);
    adcsp_port uut (.i_clk_sys(clk), .i_rst(rst), .i_conv_valid(cv), .i_conv_raw(raw),
        .i_chan_on(on), .i_rate_select(rate), .i_lead_off(lo), .i_chain_en(chain),
        .i_continuous_read_cmd(cont), .i_pin_ctl(pc), .i_pin_in(pin_w), .o_pin_out(pin_out),
        .o_pin_oe(pin_oe), .o_pin_level_bits(lvl), .o_pin_direction_bits(dirb),
        .i_power_down_n(power_down_n), .o_powered_up(up), .i_sclk(sclk), .i_cs_n(cs_n), .i_sdi(sdi),
        .o_sdo(sdo), .o_sdo_oe(sdo_oe), .o_sample_ready_n(rdy_n), .o_sdi_high_seen());
    adcsp_host host (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(sdo),
        .i_sdo_oe(sdo_oe));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : step
    task automatic check(input logic [231:0] got, input logic [231:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic end_of_test;
        if (fails == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test
    task automatic wait_up;
        for (int n = 0; n < 200 && up !== 1'b1; n++) step(1);
        check(up, 1'b1);
    endtask : wait_up
    // expected frame built from the stimulus alone
    function automatic logic [215:0] frame_of();
        logic [215:0] r;
        logic [23:0] c;
        r = {4'hc, lo.pos, lo.neg, exp_pins[0], exp_pins[1], exp_pins[2], exp_pins[3]};
        for (int k = 0; k < CH_NUM; k++) begin
            c = raw[k][23:0];
            if (raw[k] > 26'sd8388607) c = 24'h7fffff;
            if (raw[k] < -26'sd8388608) c = 24'h800000;
            if (rate == 3'h0) c[6:0] = 7'h00;
            if (rate == 3'h1) c[4:0] = 5'h00;
            r = {r[191:0], on[k] ? c : 24'h000000};
        end
        return r;
    endfunction : frame_of
    task automatic conv_read(input int i);
        step(1);
        cv = 1'b1;
        step(1);
        cv = 1'b0;
        check(rdy_n, 1'b0);
        f = frame_of();
        exp_q.push_back(chain ? {f, f[215:200]} : {f, 16'h0000});
        fork
            host.xfer(232, 1'b1);
            begin
                #60;
                check({sdo_oe, cont ? sdo : 1'b0}, 2'b10);
                if (i == 2) begin
                    #4000;
                    step(1);
                    cv = 1'b1;
                    step(1);
                    cv = 1'b0;
                end
            end
        join
        step(8);
        check({sdo_oe, rdy_n}, 2'b01);
    endtask : conv_read
    // ==========================================
    // result watcher and watchdog
    initial forever begin
        @(host.done);
        check(host.got, exp_q.pop_front());
    end
    initial begin
        #1000000;
        fails++;
        end_of_test();
    end
    // ==========================================
    // main sequence
    initial begin
        void'($urandom(84820));
        rst = 1'b1; cv = 1'b0; chain = 1'b0; cont = 1'b0; power_down_n = 1'b1;
        on = 8'hff; rate = 3'h2; lo = '0; pc = '0; ext = 4'h0; exp_pins = 4'h0;
        foreach (raw[k]) raw[k] = '0;
        step(20);
        rst = 1'b0;
        step(1);
        check({pin_oe, dirb, rdy_n}, {4'h0, 4'hf, 1'b1});
        wait_up();
        host.xfer(232, 1'b0);
        for (int i = 0; i < 4; i++) begin
            pc = {4'($urandom), 4'($urandom), 1'b1};
            ext = 4'($urandom);
            step(1);
            pc.wr = 1'b0;
            step(4);
            exp_pins = (~pc.dir & pc.level) | (pc.dir & ext);
            check({pin_oe, pin_out & pin_oe}, {~pc.dir, pc.level & ~pc.dir});
            check(lvl, exp_pins);
        end
        for (int i = 0; i < 6; i++) begin
            foreach (raw[k]) raw[k] = 26'($urandom);
            raw[0] = -26'sd8388608 - 26'(i);
            raw[1] = 26'sd8388607 + 26'(i);
            on = 8'($urandom);
            rate = 3'(i % 3);
            lo = 16'($urandom);
            chain = i[0];
            cont = (i == 4);
            conv_read(i);
        end
        host.xfer(11, 1'b0);
        conv_read(9);
        power_down_n = 1'b0;
        step(8);
        cv = 1'b1;
        step(1);
        cv = 1'b0;
        step(2);
        check({up, rdy_n}, 2'b01);
        power_down_n = 1'b1;
        wait_up();
        end_of_test();
    end
endmodule : adcsp_port_test
